// File: sim/call_ctl_chk.sv
// Port checker for the call-control sequencer, bound to its top module.
// Assumes the single mclk domain and the short sim timer values.
`timescale 1ns/1ps
module call_ctl_chk #(
  parameter int unsigned SEND_SPACE_CYCLES = 50
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire call_ctl_pkg::pins_t pins,
  input wire call_ctl_pkg::lamps_t lamps,
  input wire call_ctl_pkg::line_t line,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  int unsigned clr_cnt;
  // Counts lit cycles; small margin for sync and registering
  always_ff @(posedge mclk) begin
    if (!resetn || !lamps.clear_key_lamp) clr_cnt <= 0;
    else clr_cnt <= clr_cnt + 1;
  end
  AST_CLR_TIMED:
  assert property (clr_cnt <= SEND_SPACE_CYCLES + 4)
    else $error("clear lamp lit too long");
  AST_RESTRAIN:
  assert property (pins.restrain_signal [*8] |-> ##[0:6] lamps.restrain_lamp)
    else $error("restrain lamp not lit");
  AST_BREAK_BOTH:
  assert property (pins.dc_break [*8] |->
    ##[0:6] (lamps.restrain_lamp && lamps.break_release_lamp))
    else $error("break lamps not lit");
  AST_ANS_RING:
  assert property (pins.ring_detect [*8] |-> ##[0:6] lamps.answer_key_lamp)
    else $error("answer lamp dark while ringing");
  AST_SPK_ORIGINATE_KEY_LAMP:
  assert property (line.speaker_en |-> lamps.originate_key_lamp)
    else $error("speaker on outside originate");
  AST_MUTE:
  assert property (pins.dialer_off_normal [*8] |-> ##[0:6] !line.speaker_en)
    else $error("speaker not muted");
  AST_B_HOLD:
  assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD:
  assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_B_LAT:
  assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  AST_R_LAT:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  cover property ($rose(lamps.clear_key_lamp));
  cover property ($rose(lamps.answer_key_lamp));
  cover property ($rose(line.speaker_en));
  cover property ($rose(line.off_hook));
endmodule

bind call_control_sequencer call_ctl_chk #(
  .SEND_SPACE_CYCLES(SEND_SPACE_CYCLES)
) i_call_ctl_chk (.*);

// File: sim/call_line_model.sv
// Data set and central office line: ringing cadence and restrain relay.
// Assumes the bench requests ringing; answering trips the ringing.
`timescale 1ns/1ps
module call_line_model #(
  parameter int ON = 40,
  parameter int OFF = 30
) (
  input wire logic mclk,
  input wire logic ring_req,
  input wire logic off_hook,
  input wire logic rs_req,
  output logic ring,
  output logic rs
);
  int cnt = 0;
  initial ring = 1'b0;
  initial rs = 1'b0;
  always @(posedge mclk) begin
    cnt <= (ring_req && cnt < ON + OFF - 1) ? cnt + 1 : 0;
    // Office stops ringing once the station goes off hook
    ring <= ring_req && !off_hook && cnt < ON;
    rs <= rs_req;
  end
endmodule

// File: sim/tb_call_control_sequencer.sv
// Self-checking bench for the call-control sequencer.
// Assumes short sim timer and debounce values set at the instance.
`timescale 1ns/1ps
module tb_call_control_sequencer;
  import call_ctl_pkg::*;
  localparam int SS = 200;
  localparam int DEB = 4;
  localparam int DB = 3 + DEB + 3;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic eot_code = 1'b0;
  logic ring_req = 1'b0;
  logic rs_req = 1'b0;
  logic ring;
  logic rs;
  pins_t kb = '0;
  pins_t pw;
  lamps_t lamps;
  line_t line;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [3:0] wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd_d, d, cur;
  logic [3:0] s;
  int num_errors = 0;
  int n_tests = 0;
  always #5 mclk = ~mclk;
  always_comb begin
    pw = kb;
    pw.ring_detect = ring;
    pw.restrain_signal = rs;
  end
  call_control_sequencer #(.SEND_SPACE_CYCLES(SS), .DEBOUNCE_CYCLES(DEB))
  i_call_control_sequencer (.mclk(mclk), .resetn(resetn), .pins(pw),
    .eot_code(eot_code), .lamps(lamps), .line(line),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  call_line_model i_call_line_model (.mclk(mclk), .ring_req(ring_req),
    .off_hook(line.off_hook), .rs_req(rs_req), .ring(ring), .rs(rs));
  task summarize();
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask
  // Ready is sampled at the falling edge, where it is settled for the edge
  task wr(input logic [3:0] a, input logic [31:0] dv, input logic [3:0] sv,
    output logic [1:0] r);
    int i;
    logic ta, tw, tb;
    @(posedge mclk);
    awaddr <= a;
    wdata <= dv;
    wstrb <= sv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) break;
    end
    bready <= 1'b0;
    if (i == 64) begin
      num_errors++;
      summarize();
    end
  endtask
  task rd(input logic [3:0] a, output logic [31:0] dv, output logic [1:0] r);
    int i;
    logic ta, tr;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(negedge mclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      dv = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      if (tr) break;
    end
    rready <= 1'b0;
    if (i == 64) begin
      num_errors++;
      summarize();
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task key(input int b);
    @(posedge mclk) kb[b] <= 1'b1;
    repeat (DB) @(posedge mclk);
    kb[b] <= 1'b0;
    wt(DB);
  endtask
  function automatic logic [31:0] exp_ctrl(logic [31:0] c, logic [31:0] dv,
    logic [3:0] sv);
    return sv[0] ? {27'h0, dv[4:0]} : c;
  endfunction
  initial begin
    void'($urandom(25360));
    wt(12);
    @(posedge mclk) resetn <= 1'b1;
    wt(1);
    chk(32'(lamps), 32'h0);
    chk(32'(line), 32'h0);
    rd(CTRL_OFS, rd_d, rsp);
    chk(rd_d, 32'(CTRL_RST));
    rd(4'h8, rd_d, rsp);
    chk({rd_d[29:0], rsp}, 32'(RESP_SLVERR));
    wr(4'hC, 32'h1F, 4'hF, rsp);
    chk(32'(rsp), 32'(RESP_SLVERR));
    cur = 32'(CTRL_RST);
    for (int k = 0; k < 6; k++) begin
      d = $urandom;
      s = 4'($urandom);
      wr(CTRL_OFS, d, s, rsp);
      cur = exp_ctrl(cur, d, s);
      rd(CTRL_OFS, rd_d, rsp);
      chk(rd_d, cur);
    end
    wr(CTRL_OFS, 32'h2, 4'h1, rsp);
    @(posedge mclk) rs_req <= 1'b1;
    wt(DB);
    chk(32'(lamps.restrain_lamp), 32'h1);
    @(posedge mclk) rs_req <= 1'b0;
    @(posedge mclk) kb.dc_break <= 1'b1;
    wt(DB);
    chk(32'({lamps.restrain_lamp, lamps.break_release_lamp}), 32'h3);
    @(posedge mclk) kb.dc_break <= 1'b0;
    @(posedge mclk) ring_req <= 1'b1;
    wt(2 * DB);
    chk(32'(line.off_hook), 32'h1);
    @(posedge mclk) ring_req <= 1'b0;
    wt(100);
    chk(32'(lamps.answer_key_lamp), 32'h1);
    key(7);
    chk(32'(lamps.originate_key_lamp), 32'h0);
    key(9);
    chk(32'(lamps.clear_key_lamp), 32'h1);
    chk(32'(lamps.answer_key_lamp), 32'h0);
    wt(SS);
    chk(32'(lamps.clear_key_lamp), 32'h0);
    chk(32'(line.off_hook), 32'h0);
    key(7);
    chk(32'({lamps.originate_key_lamp, line.speaker_en}), 32'h3);
    @(posedge mclk) kb.dialer_off_normal <= 1'b1;
    wt(DB);
    chk(32'(line.speaker_en), 32'h0);
    @(posedge mclk) kb.dialer_off_normal <= 1'b0;
    key(9);
    chk(32'({lamps.originate_key_lamp, line.speaker_en}), 32'h0);
    wt(SS);
    chk(32'(line.off_hook), 32'h0);
    key(8);
    chk(32'(line.off_hook), 32'h1);
    key(9);
    wt(SS);
    @(posedge mclk) kb.forms_busy <= 1'b1;
    key(8);
    chk(32'(line.off_hook), 32'h0);
    @(posedge mclk) kb.forms_busy <= 1'b0;
    wt(DB);
    chk(32'(line.off_hook), 32'h1);
    key(9);
    wt(SS);
    wr(CTRL_OFS, 32'h12, 4'hF, rsp);
    @(posedge mclk) ring_req <= 1'b1;
    wt(2 * DB);
    chk(32'(lamps.answer_key_lamp), 32'h1);
    chk(32'(line.ringer_en), 32'h0);
    chk(32'(line.off_hook), 32'h0);
    wr(CTRL_OFS, 32'h0, 4'h1, rsp);
    wt(DB);
    chk(32'({line.ringer_en, line.off_hook}), 32'h2);
    @(posedge mclk) ring_req <= 1'b0;
    wt(DB);
    wr(CTRL_OFS, 32'h3, 4'h1, rsp);
    wt(DB);
    chk(32'({line.rx_break_normal, line.send_normal}), 32'h3);
    @(posedge mclk) ring_req <= 1'b1;
    wt(2 * DB);
    chk(32'(line.off_hook), 32'h1);
    @(posedge mclk) ring_req <= 1'b0;
    key(9);
    chk(32'(lamps.clear_key_lamp), 32'h1);
    chk(32'({line.rx_break_normal, line.send_normal}), 32'h0);
    chk(32'(lamps.answer_key_lamp), 32'h0);
    wt(SS);
    chk(32'({lamps.clear_key_lamp, line.off_hook}), 32'h0);
    wr(CTRL_OFS, 32'h2, 4'h1, rsp);
    wr(CTRL_OFS, 32'h3, 4'h1, rsp);
    wt(DB);
    key(7);
    chk(32'({lamps.originate_key_lamp, line.off_hook}), 32'h3);
    @(posedge mclk) eot_code <= 1'b1;
    @(posedge mclk) eot_code <= 1'b0;
    wt(2);
    chk(32'(lamps.originate_key_lamp), 32'h0);
    wt(SS);
    chk(32'(line.off_hook), 32'h0);
    key(8);
    chk(32'({lamps.answer_key_lamp, line.off_hook}), 32'h3);
    summarize();
  end
endmodule

// File: src/call_control_sequencer.sv
// Call-control sequencer: keys, lamps, data set relays and disconnect timer.
// Assumes pins are asynchronous to mclk; eot_code comes from mclk logic.
`timescale 1ns/1ps

// Notes on behaviour
// - Restrain lamp follows restrain; converter break lights both lamps.
// - Variant one: clear in answer or originate sets held break latch.
// - Break latch sets send space latch and clear lamp for 700 ms.
// - Variant two idles with break-normal and send-normal asserted.
// - Variant two clear sets break hold, then latches send hold.
// - Variant two clear lamp is send hold and off hook; timer drops hook.
// - Ringing asserts ring detect; answer follows by auto or by key.
// - Answer lamp lit whenever ring detect asserted, flashing with it.
// - Variant one: ring without copy mode sets held answer latch.
// - Variant one answer lamp lit by answer latch until send space.
// - Variant one: expiry of send space interval releases answer.
// - Variant two: ring without originate or copy asserts off hook.
// - Variant two: answer lamp dark on send hold; hook drops at expiry.
// - Auto answer barred by local, originate, test, paper, service, forms.
// - Ringer silent while out of service.
// - Answer key during forms or tabulation answers once it ends.
// - Variant one: answer key, no send space or originate, sets answer.
// - Variant two: answer key with send-normal, no originate: off hook.
// - Originate key ignored while in an answer condition.
// - Variant one originate latch; lamp and speaker until send space.
// - Variant two originate latch asserts off hook and holds with it.
// - Clear or end code: originate lamp and speaker off, then disconnect.
// - Dialer off-normal mutes the speaker.
module call_control_sequencer #(
  parameter int unsigned SEND_SPACE_CYCLES = call_ctl_pkg::SEND_SPACE_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = call_ctl_pkg::DEBOUNCE_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire call_ctl_pkg::pins_t pins,
  input wire logic eot_code,
  output call_ctl_pkg::lamps_t lamps,
  output call_ctl_pkg::line_t line,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import call_ctl_pkg::*;

  localparam logic [TMR_W-1:0] SS_LAST = TMR_W'(SEND_SPACE_CYCLES - 1);
  localparam logic [TMR_W-1:0] DB_LAST = TMR_W'(DEBOUNCE_CYCLES - 1);

  // Pin conditioning
  logic [N_PINS-1:0] raw;
  logic [N_PINS-1:0] clean;
  pins_t p;

  assign raw = pins;
  assign p = clean;

  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi++) begin : g_pin
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic db_r;
      logic [TMR_W-1:0] cnt_r;
      always_ff @(posedge mclk) begin
        if (!resetn) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
        end else begin
          s1_r <= raw[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      // Contact bounce must stay quiet for the whole window to count
      always_ff @(posedge mclk) begin
        if (!resetn) begin
          db_r <= 1'b0;
          cnt_r <= '0;
        end else if (s2_r != s3_r || s3_r == db_r) begin
          cnt_r <= '0;
        end else if (cnt_r == DB_LAST) begin
          db_r <= s3_r;
          cnt_r <= '0;
        end else begin
          cnt_r <= cnt_r + TMR_W'(1);
        end
      end
      assign clean[gi] = db_r;
    end
  endgenerate

  // Control register
  logic [7:0] ctrl_r;
  logic var2;
  logic auto_en;
  logic local_mode;
  logic test_mode;
  logic oos;

  assign var2 = ctrl_r[CTRL_VARIANT2];
  assign auto_en = ctrl_r[CTRL_AUTO_EN];
  assign local_mode = ctrl_r[CTRL_LOCAL];
  assign test_mode = ctrl_r[CTRL_TEST];
  assign oos = ctrl_r[CTRL_OOS];

  // Sequencing state
  logic answer_latch_r;
  logic originate_latch_r;
  logic rx_break_latch_r;
  logic send_space_latch_r;
  logic rx_break_hold_r;
  logic send_space_hold_r;
  logic off_hook_r;
  logic orig2_r;
  logic answer_pending_r;
  logic [TMR_W-1:0] tmr_r;
  logic tmr_run;
  logic expired;
  logic auto_ok;
  logic ring_go;
  logic v1_mode;
  logic rbn;
  logic snorm;

  assign rbn = !rx_break_hold_r;
  assign snorm = !send_space_hold_r;
  // Each inhibit is explicit: copy, local, test, originate, paper, service, forms
  assign auto_ok = auto_en && !p.copy_mode && !local_mode && !test_mode &&
    !originate_latch_r && !p.low_paper && !oos && !p.forms_busy;
  assign ring_go = (p.ring_detect && auto_ok) ||
    (answer_pending_r && !p.forms_busy);
  assign v1_mode = answer_latch_r || originate_latch_r;
  assign tmr_run = var2 ? (send_space_hold_r && off_hook_r)
                        : send_space_latch_r;
  assign expired = tmr_run && (tmr_r == SS_LAST);

  // One interval timer serves both variants' disconnect
  always_ff @(posedge mclk) begin
    if (!resetn || !tmr_run || expired) begin
      tmr_r <= '0;
    end else begin
      tmr_r <= tmr_r + TMR_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      answer_pending_r <= 1'b0;
    end else if (p.answer_key && p.forms_busy && !oos) begin
      answer_pending_r <= 1'b1;
    end else if (!p.forms_busy) begin
      answer_pending_r <= 1'b0;
    end
  end

  // First variant latches
  always_ff @(posedge mclk) begin
    if (!resetn || var2) begin
      answer_latch_r <= 1'b0;
      originate_latch_r <= 1'b0;
      rx_break_latch_r <= 1'b0;
      send_space_latch_r <= 1'b0;
    end else begin
      if (expired) begin
        answer_latch_r <= 1'b0;
      end else if ((ring_go && !p.copy_mode) || answer_latch_r) begin
        answer_latch_r <= 1'b1;
      end else if (p.answer_key && !send_space_latch_r &&
                   !originate_latch_r && !p.forms_busy) begin
        answer_latch_r <= 1'b1;
      end
      if (expired || answer_latch_r) begin
        originate_latch_r <= 1'b0;
      end else if (originate_latch_r ||
                   (p.originate_key && !send_space_latch_r)) begin
        originate_latch_r <= 1'b1;
      end
      rx_break_latch_r <= v1_mode &&
        (p.clear_key || rx_break_latch_r);
      if (expired) begin
        send_space_latch_r <= 1'b0;
      end else if (v1_mode && (rx_break_latch_r || eot_code ||
                               send_space_latch_r)) begin
        send_space_latch_r <= 1'b1;
      end
    end
  end

  // Second variant relays
  always_ff @(posedge mclk) begin
    if (!resetn || !var2) begin
      rx_break_hold_r <= 1'b0;
      send_space_hold_r <= 1'b0;
      off_hook_r <= 1'b0;
    end else begin
      if (expired) begin
        off_hook_r <= 1'b0;
      end else if (off_hook_r || orig2_r) begin
        off_hook_r <= 1'b1;
      end else if (ring_go && !p.copy_mode) begin
        off_hook_r <= 1'b1;
      end else if (p.answer_key && snorm && !p.forms_busy) begin
        off_hook_r <= 1'b1;
      end
      rx_break_hold_r <= (off_hook_r || p.clear_key) &&
        ((p.clear_key && rbn) || rx_break_hold_r);
      send_space_hold_r <= off_hook_r && !expired &&
        ((p.clear_key && !rbn) || eot_code ||
         send_space_hold_r);
    end
  end

  // Second variant originate latch, held through off hook
  always_ff @(posedge mclk) begin
    if (!resetn || !var2) begin
      orig2_r <= 1'b0;
    end else if (expired) begin
      orig2_r <= 1'b0;
    end else if (p.originate_key && snorm && !off_hook_r) begin
      orig2_r <= 1'b1;
    end else begin
      orig2_r <= orig2_r && off_hook_r;
    end
  end

  logic originate_key_lamp_any;
  assign originate_key_lamp_any = var2 ? orig2_r : originate_latch_r;

  // Registered outputs
  lamps_t lamps_nxt;
  line_t line_nxt;

  always_comb begin
    lamps_nxt.restrain_lamp = p.restrain_signal || p.dc_break;
    lamps_nxt.break_release_lamp = p.dc_break ||
      (var2 ? (rx_break_hold_r && snorm)
            : (rx_break_latch_r && !send_space_latch_r));
    lamps_nxt.clear_key_lamp = var2 ? (send_space_hold_r && off_hook_r)
                                    : send_space_latch_r;
    lamps_nxt.answer_key_lamp = p.ring_detect ||
      (var2 ? (off_hook_r && !orig2_r && snorm)
            : (answer_latch_r && !send_space_latch_r));
    lamps_nxt.originate_key_lamp = var2
      ? (orig2_r && off_hook_r && snorm)
      : (originate_latch_r && !send_space_latch_r);
    line_nxt.off_hook = var2 ? off_hook_r
                             : (answer_latch_r || originate_latch_r);
    line_nxt.rx_break_normal = var2 && rbn;
    line_nxt.send_normal = var2 && snorm;
    line_nxt.ringer_en = p.ring_detect && !oos &&
      !line_nxt.off_hook;
    line_nxt.speaker_en = lamps_nxt.originate_key_lamp &&
      !p.dialer_off_normal;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      lamps <= '0;
      line <= '0;
    end else begin
      lamps <= lamps_nxt;
      line <= line_nxt;
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  logic aw_full_r;
  logic w_full_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready = !w_full_r && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl_r <= CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (aw_full_r && w_full_r && !s_axi_bvalid) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_r[3:2] == CTRL_OFS[3:2]) begin
          s_axi_bresp <= RESP_OKAY;
          if (wstrb_r[0]) begin
            ctrl_r <= {3'h0, wdata_r[4:0]};
          end
        end else if (awaddr_r[3:2] == STATUS_OFS[3:2]) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read side
  logic [31:0] status_word;
  assign status_word = {20'h00000, tmr_run, answer_pending_r,
    off_hook_r, send_space_hold_r, rx_break_hold_r, originate_key_lamp_any,
    send_space_latch_r, rx_break_latch_r, answer_latch_r,
    line.off_hook, line.ringer_en, p.ring_detect};
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr[3:2] == CTRL_OFS[3:2]) begin
        s_axi_rdata <= {24'h000000, ctrl_r};
        s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_araddr[3:2] == STATUS_OFS[3:2]) begin
        s_axi_rdata <= status_word;
        s_axi_rresp <= RESP_OKAY;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: src/call_ctl_pkg.sv
// Constants, register map and carrier types for the call-control sequencer.
// Assumes a single 100 MHz clock shared by the bus and all sequencing logic.
package call_ctl_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SEND_SPACE_MS = 700;
  localparam int unsigned DEBOUNCE_US = 5000;
  localparam int unsigned SEND_SPACE_CYC =
    SEND_SPACE_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1000000);
  localparam int unsigned TMR_W = 27;
  localparam int unsigned N_PINS = 10;

  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [7:0] CTRL_RST = 8'h02;

  localparam int unsigned CTRL_VARIANT2 = 0;
  localparam int unsigned CTRL_AUTO_EN = 1;
  localparam int unsigned CTRL_LOCAL = 2;
  localparam int unsigned CTRL_TEST = 3;
  localparam int unsigned CTRL_OOS = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic clear_key;
    logic answer_key;
    logic originate_key;
    logic restrain_signal;
    logic ring_detect;
    logic dc_break;
    logic copy_mode;
    logic low_paper;
    logic forms_busy;
    logic dialer_off_normal;
  } pins_t;

  typedef struct packed {
    logic restrain_lamp;
    logic break_release_lamp;
    logic clear_key_lamp;
    logic answer_key_lamp;
    logic originate_key_lamp;
  } lamps_t;

  typedef struct packed {
    logic off_hook;
    logic rx_break_normal;
    logic send_normal;
    logic ringer_en;
    logic speaker_en;
  } line_t;

endpackage
